// file: pmc2_pkg.sv
// Constants for the C2 pin control and PCI interrupt steering block
package pmc2_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets and dword indices
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PIN_CTRL  = 8'h50;
  localparam logic [7:0] OFS_TRIG_SEL  = 8'h54;
  localparam logic [7:0] OFS_STEERING  = 8'h56;
  localparam logic [5:0] DW_PIN_CTRL   = OFS_PIN_CTRL[7:2];
  localparam logic [5:0] DW_IRQ_CTRL   = OFS_TRIG_SEL[7:2];

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C2_CACHE_SLEEP_BIT = 0;
  localparam int C2_DRAM_STOP_BIT   = 1;
  localparam int C2_MASTER_BIT      = 2;
  localparam int C2_CPU_STOP_BIT    = 3;
  localparam int C2_BYTE_LSB        = 0;
  localparam int C3_BYTE_LSB        = 8;
  localparam int POS_BYTE_LSB       = 16;
  localparam int THERM_BYTE_LSB     = 24;
  localparam int TRIG_LSB           = 0;
  localparam int TRIG_W             = 4;
  localparam int STEER_LSB          = 16;
  localparam int ROUTE_W            = 4;
  localparam int NUM_LINES          = 4;
  localparam int NUM_IRQ            = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] PIN_CTRL_RST = 32'h0000_0001;
  localparam logic [3:0]  TRIG_RST     = 4'h0;
  localparam logic [15:0] STEER_RST    = 16'h0000;
  localparam logic [3:0]  ROUTE_NONE   = 4'h0;

  // Routing code to controller input; code 0 is never looked up
  localparam logic [3:0] ROUTE_LUT [NUM_IRQ] = '{
    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
    4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF
  };

endpackage

// file: pmc2_irq_cond.sv
// One PCI interrupt line: pin synchroniser and trigger conditioning
`timescale 1ns/10ps
`default_nettype none

module pmc2_irq_cond
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  input  wire logic edge_sel_i,
  output logic      req_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic req;
  } pmc2_cond_t;

  pmc2_cond_t cur;
  pmc2_cond_t next_cur;

  // Level mode asserts while the pin is low; edge mode pulses on a rise
  always_comb
  begin
    next_cur      = cur;
    next_cur.s1   = pin_i;
    next_cur.s2   = cur.s1;
    next_cur.prev = cur.s2;
    if (edge_sel_i)
      next_cur.req = cur.s2 & ~cur.prev;
    else
      next_cur.req = ~cur.s2;
  end

  // State register; pin idles high
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cur <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, req: 1'b0};
    else
      cur <= next_cur;
  end

  assign req_o = cur.req;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_rise;
    cur.s2 && !cur.prev && edge_sel_i;
  endsequence

  property p_level_low;
    @(posedge clk_i) disable iff (rst_i)
    (!edge_sel_i && !cur.s2) |=> req_o;
  endproperty
  a_level_low: assert property (p_level_low) else $error("level line not requesting");

  property p_level_high;
    @(posedge clk_i) disable iff (rst_i)
    (!edge_sel_i && cur.s2) |=> !req_o;
  endproperty
  a_level_high: assert property (p_level_high) else $error("idle level line requesting");

  property p_edge_pulse;
    @(posedge clk_i) disable iff (rst_i)
    s_rise |=> req_o ##1 !req_o;
  endproperty
  a_edge_pulse: assert property (p_edge_pulse) else $error("edge pulse wrong width");

endmodule
`default_nettype wire

// file: pmc2_top.sv
// C2 low-power pin enables and PCI interrupt trigger and steering registers
// Operation
// - cpu_stop_c2_enable drives active-low CPU stop in C2 when its function selected.
// - c2_master_enable drives active-low stop clock during C2.
// - Without c2_master_enable, no other C2 low-power output asserts.
// - dram_stop_c2_enable drives active-low DRAM stop in C2 when function selected.
// - cache_sleep_c2_enable, reset 1, drives active-high cache sleep in C2 when its function selected.
// - Byte 0 holds C2 enables, byte 1 C3, byte 2 power-on suspend.
// - Byte 3 controls automatic thermal throttling on CPU over-temperature.
// - Trigger select bit 0: line active-low level triggered; reset state.
// - Trigger select bit 1: line active-high edge triggered.
// - Trigger select bits 7 to 4 read as zero.
// - Four-bit steering field per line routes it to interrupt controller.
`timescale 1ns/10ps
`default_nettype none

module pmc2_top
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  input  wire logic        c2_state_i,
  input  wire logic        cpu_stop_fn_sel_i,
  input  wire logic        dram_stop_fn_sel_i,
  input  wire logic        cache_sleep_fn_sel_i,
  input  wire logic        pci_int_a_pin_i,
  input  wire logic        pci_int_b_pin_i,
  input  wire logic        pci_int_c_pin_i,
  input  wire logic        pci_int_d_pin_i,
  output logic             stop_clock_n_o,
  output logic             cpu_stop_n_o,
  output logic             dram_stop_n_o,
  output logic             cache_sleep_o,
  output logic      [7:0]  c3_enables_o,
  output logic      [7:0]  pos_enables_o,
  output logic      [7:0]  thermal_ctrl_o,
  output logic      [15:0] pic_irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] pin_ctrl;
    logic [3:0]  trig_sel;
    logic [15:0] steering;
    logic [31:0] rdata;
    logic        stop_clock_n;
    logic        cpu_stop_n;
    logic        dram_stop_n;
    logic        cache_sleep;
    logic [15:0] irq;
  } pmc2_state_t;

  pmc2_state_t cur;
  pmc2_state_t next_cur;

  logic [pmc2_pkg::NUM_LINES-1:0] pins;
  logic [pmc2_pkg::NUM_LINES-1:0] line_req;
  logic [7:0]                     c2_byte;
  logic                           c2_live;
  logic                           hit_pin;
  logic                           hit_irq;

  assign pins     = {pci_int_d_pin_i, pci_int_c_pin_i, pci_int_b_pin_i, pci_int_a_pin_i};
  assign c2_byte  = cur.pin_ctrl[pmc2_pkg::C2_BYTE_LSB +: 8];
  assign c2_live  = c2_state_i & c2_byte[pmc2_pkg::C2_MASTER_BIT];
  assign hit_pin  = (cfg_addr_i[7:2] == pmc2_pkg::DW_PIN_CTRL);
  assign hit_irq  = (cfg_addr_i[7:2] == pmc2_pkg::DW_IRQ_CTRL);

  // ----------------------------------------------------------------
  // Per-line trigger conditioning
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < pmc2_pkg::NUM_LINES; g++)
    begin : g_line
      pmc2_irq_cond u_cond
      (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pin_i      (pins[g]),
        .edge_sel_i (cur.trig_sel[g]),
        .req_o      (line_req[g])
      );
    end
  endgenerate

  // Register access, pin outputs and interrupt steering
  always_comb
  begin
    logic [3:0] code;
    code     = pmc2_pkg::ROUTE_NONE;
    next_cur = cur;
    // Writes by byte lane
    if (cfg_wr_i && hit_pin)
    begin
      for (int b = 0; b < 4; b++)
        if (cfg_be_i[b])
          next_cur.pin_ctrl[8*b +: 8] = cfg_wdata_i[8*b +: 8];
    end
    if (cfg_wr_i && hit_irq)
    begin
      if (cfg_be_i[0])
        next_cur.trig_sel = cfg_wdata_i[pmc2_pkg::TRIG_LSB +: pmc2_pkg::TRIG_W];
      if (cfg_be_i[2])
        next_cur.steering[7:0] = cfg_wdata_i[pmc2_pkg::STEER_LSB +: 8];
      if (cfg_be_i[3])
        next_cur.steering[15:8] = cfg_wdata_i[pmc2_pkg::STEER_LSB + 8 +: 8];
    end
    // Read data; unmapped dwords and reserved bits read zero
    if (cfg_rd_i)
    begin
      if (hit_pin)
        next_cur.rdata = cur.pin_ctrl;
      else if (hit_irq)
        next_cur.rdata = {cur.steering, 8'h00, 4'h0, cur.trig_sel};
      else
        next_cur.rdata = 32'h0000_0000;
    end
    // C2 low-power outputs, all gated by the master enable
    next_cur.stop_clock_n = ~c2_live;
    next_cur.cpu_stop_n   = ~(c2_live & c2_byte[pmc2_pkg::C2_CPU_STOP_BIT]
                              & cpu_stop_fn_sel_i);
    next_cur.dram_stop_n  = ~(c2_live & c2_byte[pmc2_pkg::C2_DRAM_STOP_BIT]
                              & dram_stop_fn_sel_i);
    next_cur.cache_sleep  = c2_live & c2_byte[pmc2_pkg::C2_CACHE_SLEEP_BIT]
                            & cache_sleep_fn_sel_i;
    // Steer each line to its controller input
    next_cur.irq = 16'h0000;
    for (int l = 0; l < pmc2_pkg::NUM_LINES; l++)
    begin
      code = cur.steering[pmc2_pkg::ROUTE_W*l +: pmc2_pkg::ROUTE_W];
      if (code != pmc2_pkg::ROUTE_NONE)
        next_cur.irq[pmc2_pkg::ROUTE_LUT[code]] = next_cur.irq[pmc2_pkg::ROUTE_LUT[code]]
                                                  | line_req[l];
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cur              <= '0;
      cur.pin_ctrl     <= pmc2_pkg::PIN_CTRL_RST;
      cur.trig_sel     <= pmc2_pkg::TRIG_RST;
      cur.steering     <= pmc2_pkg::STEER_RST;
      cur.stop_clock_n <= 1'b1;
      cur.cpu_stop_n   <= 1'b1;
      cur.dram_stop_n  <= 1'b1;
    end
    else
      cur <= next_cur;
  end

  // Outputs
  assign cfg_rdata_o    = cur.rdata;
  assign stop_clock_n_o = cur.stop_clock_n;
  assign cpu_stop_n_o   = cur.cpu_stop_n;
  assign dram_stop_n_o  = cur.dram_stop_n;
  assign cache_sleep_o  = cur.cache_sleep;
  assign c3_enables_o   = cur.pin_ctrl[pmc2_pkg::C3_BYTE_LSB +: 8];
  assign pos_enables_o  = cur.pin_ctrl[pmc2_pkg::POS_BYTE_LSB +: 8];
  assign thermal_ctrl_o = cur.pin_ctrl[pmc2_pkg::THERM_BYTE_LSB +: 8];
  assign pic_irq_o      = cur.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_c2_armed;
    c2_state_i && c2_byte[pmc2_pkg::C2_MASTER_BIT];
  endsequence

  property p_stop_clock_n;
    s_c2_armed |=> !stop_clock_n_o;
  endproperty
  a_stop_clock_n: assert property (p_stop_clock_n) else $error("stop clock not asserted in C2");

  property p_stop_clock_n_off;
    !(c2_state_i && c2_byte[pmc2_pkg::C2_MASTER_BIT]) |=> stop_clock_n_o;
  endproperty
  a_stop_clock_n_off: assert property (p_stop_clock_n_off) else $error("stop clock asserted outside C2");

  property p_master_gate;
    !c2_byte[pmc2_pkg::C2_MASTER_BIT] |=> (cpu_stop_n_o && dram_stop_n_o && !cache_sleep_o);
  endproperty
  a_master_gate: assert property (p_master_gate) else $error("C2 output without master");

  property p_cpu_stop;
    s_c2_armed and (c2_byte[pmc2_pkg::C2_CPU_STOP_BIT] && cpu_stop_fn_sel_i)
      |=> !cpu_stop_n_o;
  endproperty
  a_cpu_stop: assert property (p_cpu_stop) else $error("cpu stop missing in C2");

  property p_dram_stop;
    !(c2_byte[pmc2_pkg::C2_DRAM_STOP_BIT] && dram_stop_fn_sel_i) |=> dram_stop_n_o;
  endproperty
  a_dram_stop: assert property (p_dram_stop) else $error("dram stop while disabled");

  property p_cache_sleep;
    s_c2_armed and (c2_byte[pmc2_pkg::C2_CACHE_SLEEP_BIT] && cache_sleep_fn_sel_i)
      |=> cache_sleep_o;
  endproperty
  a_cache_sleep: assert property (p_cache_sleep) else $error("cache sleep missing in C2");

  property p_therm_write;
    (cfg_wr_i && hit_pin && cfg_be_i[3]) |=> (thermal_ctrl_o == $past(cfg_wdata_i[31:24]));
  endproperty
  a_therm_write: assert property (p_therm_write) else $error("thermal byte not written");

  property p_c3_write;
    (cfg_wr_i && hit_pin && cfg_be_i[1]) |=> (c3_enables_o == $past(cfg_wdata_i[15:8]));
  endproperty
  a_c3_write: assert property (p_c3_write) else $error("C3 byte not written");

  property p_rsvd_zero;
    (cfg_rd_i && hit_irq) |=> (cfg_rdata_o[15:4] == 12'h000);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

  property p_steer_write;
    (cfg_wr_i && hit_irq && cfg_be_i[3]) |=> (cur.steering[15:8] == $past(cfg_wdata_i[31:24]));
  endproperty
  a_steer_write: assert property (p_steer_write) else $error("steering not written");

  property p_unrouted;
    (cur.steering == 16'h0000) |=> (pic_irq_o == 16'h0000);
  endproperty
  a_unrouted: assert property (p_unrouted) else $error("unrouted line raised irq");

endmodule
`default_nettype wire

// file: pmc2_int_src.sv
// Model of the four PCI interrupt sources standing behind the interrupt pins
`timescale 1ns/10ps
`default_nettype none

module pmc2_int_src
(
  input  wire logic       clk_i,
  input  wire logic [3:0] req_i,
  input  wire logic [3:0] edge_mode_i,
  output logic      [3:0] pin_o
);
  // Level sources pull a pulled-up line low; edge sources drive it high
  always_ff @(posedge clk_i)
  begin
    pin_o <= req_i ^ ~edge_mode_i;
  end
endmodule

`default_nettype wire

// file: tb.sv
// Self-checking bench for the C2 pin control and PCI interrupt steering block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); end end

module tb;
  logic        clk_i, rst_i, cfg_wr_i, cfg_rd_i, c2_state_i;
  logic        cpu_sel, dram_sel, cache_sel;
  logic [7:0]  cfg_addr_i;
  logic [3:0]  cfg_be_i, src_req, src_edge;
  logic [31:0] cfg_wdata_i, rd, pc, v;
  logic [3:0]  trig, code;
  logic [15:0] steer;
  wire  [31:0] rdata;
  wire  [3:0]  pin;
  wire  [7:0]  c3, pos, therm;
  wire  [15:0] pic;
  wire         stp_n, cpu_n, dram_n, zz;
  int          err_count, n_compared, pulses;
  logic [7:0]  addrs [4] = '{8'h50, 8'h54, 8'h56, 8'h5C};

  pmc2_top dut (.clk_i(clk_i), .rst_i(rst_i), .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(rdata),
    .c2_state_i(c2_state_i), .cpu_stop_fn_sel_i(cpu_sel), .dram_stop_fn_sel_i(dram_sel),
    .cache_sleep_fn_sel_i(cache_sel), .pci_int_a_pin_i(pin[0]), .pci_int_b_pin_i(pin[1]),
    .pci_int_c_pin_i(pin[2]), .pci_int_d_pin_i(pin[3]), .stop_clock_n_o(stp_n),
    .cpu_stop_n_o(cpu_n), .dram_stop_n_o(dram_n), .cache_sleep_o(zz), .c3_enables_o(c3),
    .pos_enables_o(pos), .thermal_ctrl_o(therm), .pic_irq_o(pic));

  pmc2_int_src src (.clk_i(clk_i), .req_i(src_req), .edge_mode_i(src_edge), .pin_o(pin));

  // Clock generation
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Expected C2 outputs: {stop_n, cpu_n, dram_n, sleep}
  function automatic logic [3:0] c2_exp(input logic [3:0] en, input logic c2,
                                        input logic cs, input logic ds, input logic zs);
    logic m;
    m = c2 & en[2];
    return {~m, ~(m & en[3] & cs), ~(m & en[1] & ds), m & en[0] & zs};
  endfunction

  // Register port cycles
  task cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_i);
    cfg_addr_i  <= a;
    cfg_be_i    <= be;
    cfg_wdata_i <= d;
    cfg_wr_i    <= 1'b1;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    for (int b = 0; b < 4; b++)
      if (be[b] && a[7:2] == 6'h14) pc[8*b +: 8] = d[8*b +: 8];
    if (a[7:2] == 6'h15 && be[0]) trig = d[3:0];
    if (a[7:2] == 6'h15 && be[2]) steer[7:0] = d[23:16];
    if (a[7:2] == 6'h15 && be[3]) steer[15:8] = d[31:24];
  endtask

  task cfg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    cfg_addr_i <= a;
    cfg_rd_i   <= 1'b1;
    @(posedge clk_i);
    cfg_rd_i <= 1'b0;
    #1 d = rdata;
  endtask

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {cfg_wr_i, cfg_rd_i, c2_state_i, cpu_sel, dram_sel, cache_sel} = '0;
    {cfg_addr_i, cfg_be_i, cfg_wdata_i, src_req, src_edge} = '0;
    err_count = 0;
    n_compared = 0;
    pc = 32'h0000_0001;
    trig = '0;
    steer = '0;
    rst_i = 1'b1;
    v = $urandom(58);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    cfg_read(8'h50, rd);
    `CHK(rd, 32'h0000_0001)
    cfg_read(8'h54, rd);
    `CHK(rd, 32'h0)
    $display("test reset done");
    // Random register traffic, first write all ones into the trigger dword
    for (int i = 0; i < 24; i++)
    begin
      v = $urandom;
      code = v[3:0];
      cfg_write(i == 0 ? 8'h54 : addrs[v[5:4]], i == 0 ? 4'hF : code,
                i == 0 ? 32'hFFFF_FFFF : $urandom);
      cfg_read(8'h50, rd);
      `CHK(rd, pc)
      `CHK({therm, pos, c3}, pc[31:8])
      cfg_read(addrs[v[7:6]], rd);
      if (v[7:6] == 2'd0) `CHK(rd, pc)
      if (v[7:6] == 2'd3) `CHK(rd, 32'h0)
      if (v[7:6] == 2'd1 || v[7:6] == 2'd2) `CHK(rd, {steer, 12'h000, trig})
    end
    cfg_write(8'h54, 4'hF, 32'h0);
    $display("test registers done");
    // C2 outputs over random enables, state and function selects
    for (int i = 0; i < 40; i++)
    begin
      v = $urandom;
      if (i == 0) v[7:0] = 8'hFB;
      cfg_write(8'h50, 4'h1, {28'h0, v[3:0]});
      c2_state_i <= v[4];
      {cpu_sel, dram_sel, cache_sel} <= v[7:5];
      repeat (2) @(posedge clk_i);
      #1 `CHK({stp_n, cpu_n, dram_n, zz}, c2_exp(v[3:0], v[4], v[7], v[6], v[5]))
    end
    c2_state_i <= 1'b0;
    $display("test c2 done");
    // Each line in level and edge mode, routed to a random input
    for (int l = 0; l < 4; l++)
    begin
      code = 4'(1 + $urandom % 15);
      cfg_write(8'h56, 4'hC, 32'(code) << (16 + 4 * l));
      src_req[l] <= 1'b1;
      repeat (7) @(posedge clk_i);
      #1 `CHK(pic, 16'h1 << code)
      src_req[l] <= 1'b0;
      repeat (7) @(posedge clk_i);
      #1 `CHK(pic, 16'h0)
      cfg_write(8'h54, 4'h1, 32'h1 << l);
      src_edge[l] <= 1'b1;
      repeat (4) @(posedge clk_i);
      src_req[l] <= 1'b1;
      pulses = 0;
      for (int c = 0; c < 12; c++)
      begin
        @(posedge clk_i);
        #1 pulses += (pic === 16'h1 << code);
      end
      `CHK(pulses, 1)
      src_req[l] <= 1'b0;
      cfg_write(8'h54, 4'hD, 32'h0);
      src_edge[l] <= 1'b0;
      src_req[l] <= 1'b1;
      repeat (7) @(posedge clk_i);
      #1 `CHK(pic, 16'h0)
      src_req[l] <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    $display("test interrupts done");
    end_of_test();
  end
endmodule

`default_nettype wire
